//--- src/pmuc_app_config_regs.sv
// Application configuration register group with pin and event gating
`timescale 1ns/10ps
`default_nettype none

module pmuc_app_config_regs import pmuc_pkg::*; #(
   parameter int STUCK_CYCLES = STUCK_CLOCK_CYCLES,
   parameter int BLANK_SHORT = BLANK_SHORT_CYCLES,
   parameter int BLANK_MID = BLANK_MID_CYCLES,
   parameter int BLANK_LONG = BLANK_LONG_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regRead,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic sclPin,
   input wire logic ioPinZeroPin,
   input wire logic ioPinZeroIsInput,
   input wire logic ioPinTwoIsInput,
   input wire logic ioPinTwoIsOpenDrain,
   input wire logic ioPinThreeIsInput,
   input wire logic ioPinThreeIsOpenDrain,
   input wire logic irqActive,
   input wire logic ioRailLow,
   input wire logic railARamp,
   input wire logic railBRamp,
   input wire logic pgoodRawA,
   input wire logic pgoodRawB,
   input wire logic ocHitA,
   input wire logic ocHitB,
   output logic linkFourWire,
   output logic contHighSpeedEn,
   output logic fastPlusTimingEn,
   output logic linkSupplySel,
   output logic linkLogicReset,
   output logic inputPinSupplySel,
   output logic irqOut,
   output logic irqOe,
   output logic ioLockoutCompEn,
   output logic ioLockoutActive,
   output logic pgoodA,
   output logic pgoodB,
   output logic ocEventA,
   output logic ocEventB,
   output logic otpReloadTrigger,
   output logic pin1PullDown,
   output logic pin2PullDown,
   output logic pin2PullUp,
   output logic pin3PullDown,
   output logic pin3PullUp,
   output logic pin4PullDown
);
   typedef struct packed {
      logic [7:0] linkReg;
      logic [7:0] appReg;
      logic [7:0] maskReg;
      logic [7:0] pullReg;
      logic [7:0] rdData;
      logic rdValid;
      logic sclMeta;
      logic sclSync;
      logic pin0Meta;
      logic pin0Sync;
      logic pin0Prev;
      logic reloadPulse;
      logic fourWire;
      logic contHs;
      logic fastPlus;
      logic linkSupply;
      logic inSupply;
      logic irqOut;
      logic irqOe;
      logic lockCompEn;
      logic lockActive;
      logic pgA;
      logic pgB;
      logic pd1;
      logic pd2;
      logic pu2;
      logic pd3;
      logic pu3;
      logic pd4;
   } pmuc_regs_state_type;

   pmuc_regs_state_type state;
   pmuc_regs_state_type next_state;
   logic rstMeta_n;
   logic rstSync_n;
   logic irqLevel;
   logic fourWireNow;
   logic [1:0] ocHit;
   logic [1:0] railRamp;
   logic [1:0] ocEvent;
   logic [1:0][1:0] ocCode;

   // Reset released through two flops, asserted without the clock
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // Register access, pin sampling and derived controls; overcurrent events and link reset come from the submodules
   always_comb begin
      next_state = state;
      fourWireNow = !state.linkReg[B_LINK_TWO_WIRE];
      // Reserved bits are stored but decoded nowhere
      if (regWrite) begin
         case (regAddr)
            OFS_LINK: next_state.linkReg = regWrData;
            OFS_APP: next_state.appReg = regWrData;
            OFS_MASK: next_state.maskReg = regWrData;
            OFS_PULL: next_state.pullReg = regWrData;
            default: ;
         endcase
      end
      // Unmapped reads answer zero so the host never sees stale data
      next_state.rdValid = regRead;
      if (regRead) begin
         case (regAddr)
            OFS_LINK: next_state.rdData = state.linkReg;
            OFS_APP: next_state.rdData = state.appReg;
            OFS_MASK: next_state.rdData = state.maskReg;
            OFS_PULL: next_state.rdData = state.pullReg;
            default: next_state.rdData = '0;
         endcase
      end
      // Pin synchronisers
      next_state.sclMeta = sclPin;
      next_state.sclSync = state.sclMeta;
      next_state.pin0Meta = ioPinZeroPin;
      next_state.pin0Sync = state.pin0Meta;
      next_state.pin0Prev = state.pin0Sync;
      // Link mode controls for the serial interface logic
      next_state.fourWire = fourWireNow;
      next_state.contHs = state.linkReg[B_CONT_HS];
      next_state.fastPlus = state.linkReg[B_FAST_PLUS];
      next_state.linkSupply = state.linkReg[B_LINK_SUPPLY];
      next_state.inSupply = state.appReg[B_IN_SUPPLY];
      // Interrupt pin; open drain can only pull low, so it drives the low level
      irqLevel = irqActive == state.appReg[B_IRQ_HIGH];
      if (state.appReg[B_IRQ_OD]) begin
         next_state.irqOut = 1'b0;
         next_state.irqOe = !irqLevel;
      end else begin
         next_state.irqOut = irqLevel;
         next_state.irqOe = 1'b1;
      end
      // I/O rail lockout and its comparator
      next_state.lockCompEn = !state.maskReg[B_IO_LOCK_DIS];
      next_state.lockActive = ioRailLow && !state.maskReg[B_IO_LOCK_DIS];
      // Power-good keeps its prior value while a held rail ramps
      if (!(state.maskReg[B_PG_HOLD_A] && railARamp)) begin
         next_state.pgA = pgoodRawA;
      end
      if (!(state.maskReg[B_PG_HOLD_B] && railBRamp)) begin
         next_state.pgB = pgoodRawB;
      end
      // Reload on a rising edge of pin zero, only while it is an input
      next_state.reloadPulse = state.maskReg[B_RELOAD] && ioPinZeroIsInput
         && state.pin0Sync && !state.pin0Prev;
      // Pulls; four-wire takeover overrules the pin settings of three and four
      next_state.pd2 = state.pullReg[B_PULL2] && ioPinTwoIsInput;
      next_state.pu2 = state.pullReg[B_PULL2] && ioPinTwoIsOpenDrain && !ioPinTwoIsInput;
      next_state.pd3 = state.pullReg[B_PULL3] && ioPinThreeIsInput && !fourWireNow;
      next_state.pu3 = state.pullReg[B_PULL3] && ioPinThreeIsOpenDrain
         && !ioPinThreeIsInput && !fourWireNow;
      next_state.pd4 = state.pullReg[B_PULL4] && !fourWireNow;
      next_state.pd1 = state.pullReg[B_PULL1];
   end

   // State register
   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= '0;
         state.linkReg <= RST_LINK;
         state.appReg <= RST_APP;
         state.maskReg <= RST_MASK;
         state.pullReg <= RST_PULL;
         state.fourWire <= !RST_LINK[B_LINK_TWO_WIRE];
         state.irqOut <= 1'b1;
         state.irqOe <= 1'b1;
         state.lockCompEn <= 1'b1;
         state.sclMeta <= 1'b1; // Idle high, so no false low count after reset
         state.sclSync <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // Overcurrent blanking, one instance per rail (index 0 is rail A)
   assign ocHit = {ocHitB, ocHitA};
   assign railRamp = {railBRamp, railARamp};
   assign ocCode[0] = state.maskReg[B_OC_A_HI:B_OC_A_LO];
   assign ocCode[1] = state.maskReg[B_OC_B_HI:B_OC_B_LO];

   generate
      for (genvar r = 0; r < 2; r++) begin : gRail
         pmuc_oc_blank #(
            .SHORT_CYCLES(BLANK_SHORT),
            .MID_CYCLES(BLANK_MID),
            .LONG_CYCLES(BLANK_LONG)
         ) uBlank (
            .clk_sys(clk_sys),
            .rstSync_n(rstSync_n),
            .blankCode(ocCode[r]),
            .rampActive(railRamp[r]),
            .overcurrentHit(ocHit[r]),
            .overcurrentEvent(ocEvent[r])
         );
      end
   endgenerate

   // Watchdog only runs in two-wire mode, clock seen after synchronising
   pmuc_stuck_clock #(
      .LIMIT_CYCLES(STUCK_CYCLES)
   ) uStuck (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_n),
      .timeoutEnable(state.appReg[B_STUCK_TO]),
      .twoWireMode(state.linkReg[B_LINK_TWO_WIRE]),
      .clockLow(!state.sclSync),
      .linkResetPulse(linkLogicReset)
   );

   // Outputs straight from flops
   assign regRdData = state.rdData;
   assign regRdValid = state.rdValid;
   assign linkFourWire = state.fourWire;
   assign contHighSpeedEn = state.contHs;
   assign fastPlusTimingEn = state.fastPlus;
   assign linkSupplySel = state.linkSupply;
   assign inputPinSupplySel = state.inSupply;
   assign irqOut = state.irqOut;
   assign irqOe = state.irqOe;
   assign ioLockoutCompEn = state.lockCompEn;
   assign ioLockoutActive = state.lockActive;
   assign pgoodA = state.pgA;
   assign pgoodB = state.pgB;
   assign ocEventA = ocEvent[0];
   assign ocEventB = ocEvent[1];
   assign otpReloadTrigger = state.reloadPulse;
   assign pin1PullDown = state.pd1;
   assign pin2PullDown = state.pd2;
   assign pin2PullUp = state.pu2;
   assign pin3PullDown = state.pd3;
   assign pin3PullUp = state.pu3;
   assign pin4PullDown = state.pd4;

   // Checks
   default clocking cbChk @(posedge clk_sys);
   endclocking
   default disable iff (!rstSync_n);

   property p_four_wire;
      !state.linkReg[B_LINK_TWO_WIRE] |=> linkFourWire && !pin4PullDown && !pin3PullUp;
   endproperty
   a_four_wire: assert property (p_four_wire) else $error("four-wire takeover missing");

   property p_speed_modes;
      regWrite && regAddr == OFS_LINK |=> ##1
         contHighSpeedEn == $past(regWrData[B_CONT_HS], 2)
         && fastPlusTimingEn == $past(regWrData[B_FAST_PLUS], 2);
   endproperty
   a_speed_modes: assert property (p_speed_modes) else $error("speed mode not applied");

   property p_stuck_cause;
      linkLogicReset |-> $past(state.appReg[B_STUCK_TO]) && !$past(state.sclSync)
         && $past(state.linkReg[B_LINK_TWO_WIRE]);
   endproperty
   a_stuck_cause: assert property (p_stuck_cause) else $error("link reset without cause");

   property p_irq_push_pull;
      !state.appReg[B_IRQ_OD] |=> irqOe
         && irqOut == ($past(irqActive) == $past(state.appReg[B_IRQ_HIGH]));
   endproperty
   a_irq_push_pull: assert property (p_irq_push_pull) else $error("push-pull level wrong");

   property p_irq_open_drain;
      state.appReg[B_IRQ_OD] |=> !irqOut
         && irqOe == ($past(irqActive) != $past(state.appReg[B_IRQ_HIGH]));
   endproperty
   a_irq_open_drain: assert property (p_irq_open_drain) else $error("open drain wrong");

   property p_lockout_off;
      state.maskReg[B_IO_LOCK_DIS] |=> !ioLockoutCompEn && !ioLockoutActive;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("lockout still active");

   property p_pgood_hold;
      state.maskReg[B_PG_HOLD_B] && railBRamp |=> $stable(pgoodB);
   endproperty
   a_pgood_hold: assert property (p_pgood_hold) else $error("power-good moved in ramp");

   property p_pgood_follow;
      !(state.maskReg[B_PG_HOLD_A] && railARamp) |=> pgoodA == $past(pgoodRawA);
   endproperty
   a_pgood_follow: assert property (p_pgood_follow) else $error("power-good not updated");

   property p_oc_never;
      ocHitB && state.maskReg[B_OC_B_HI:B_OC_B_LO] == OC_NEVER |=> ocEventB;
   endproperty
   a_oc_never: assert property (p_oc_never) else $error("overcurrent event lost");

   property p_oc_ramp;
      railARamp && state.maskReg[B_OC_A_HI:B_OC_A_LO] != OC_NEVER
         ##1 state.maskReg[B_OC_A_HI:B_OC_A_LO] != OC_NEVER |-> !ocEventA [*2];
   endproperty
   a_oc_ramp: assert property (p_oc_ramp) else $error("event not blanked after ramp");

   property p_reload;
      otpReloadTrigger |-> $past(state.maskReg[B_RELOAD]) && $past(ioPinZeroIsInput);
   endproperty
   a_reload: assert property (p_reload) else $error("reload without enable");

   property p_pull_pin2;
      state.pullReg[B_PULL2] && ioPinTwoIsInput |=> pin2PullDown && !pin2PullUp;
   endproperty
   a_pull_pin2: assert property (p_pull_pin2) else $error("pin two pull wrong");

   property p_pull_pin1;
      regWrite && regAddr == OFS_PULL |=> ##1 pin1PullDown == $past(regWrData[B_PULL1], 2);
   endproperty
   a_pull_pin1: assert property (p_pull_pin1) else $error("pin one pull wrong");

   c_stuck: cover property (linkLogicReset);
   c_reload: cover property (otpReloadTrigger);
   c_blank_hit: cover property (railBRamp && ocHitB && ocCode[1] != OC_NEVER);
   c_four_wire: cover property (linkFourWire && regRdValid);
endmodule

`default_nettype wire

//--- src/pmuc_oc_blank.sv
// Overcurrent event blanking for one rail during and after a voltage ramp
`timescale 1ns/10ps
`default_nettype none

module pmuc_oc_blank import pmuc_pkg::*; #(
   parameter int SHORT_CYCLES = BLANK_SHORT_CYCLES,
   parameter int MID_CYCLES = BLANK_MID_CYCLES,
   parameter int LONG_CYCLES = BLANK_LONG_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstSync_n,
   input wire logic [1:0] blankCode,
   input wire logic rampActive,
   input wire logic overcurrentHit,
   output logic overcurrentEvent
);
   typedef struct packed {
      logic [BLANK_CNT_W-1:0] tail;
      logic ocEvent;
   } pmuc_blank_state_type;

   pmuc_blank_state_type state;
   pmuc_blank_state_type next_state;
   logic [BLANK_CNT_W-1:0] tailLoad;
   logic blanked;

   // Tail reloads while ramping, so it counts only after the ramp ends
   always_comb begin
      next_state = state;
      unique case (blankCode)
         OC_NEVER: tailLoad = '0;
         OC_SHORT: tailLoad = BLANK_CNT_W'(SHORT_CYCLES);
         OC_MID: tailLoad = BLANK_CNT_W'(MID_CYCLES);
         OC_LONG: tailLoad = BLANK_CNT_W'(LONG_CYCLES);
      endcase
      if (rampActive) begin
         next_state.tail = tailLoad;
      end else if (state.tail != '0) begin
         next_state.tail = state.tail - 1'b1;
      end
      // Code change to zero stops blanking at once
      blanked = (blankCode != OC_NEVER) && (rampActive || state.tail != '0);
      next_state.ocEvent = overcurrentHit && !blanked;
   end

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign overcurrentEvent = state.ocEvent;
endmodule

`default_nettype wire

//--- src/pmuc_pkg.sv
// Register map, field positions and timing constants of the configuration group
package pmuc_pkg;
   localparam int ADDR_W = 9;
   localparam logic [8:0] OFS_LINK = 9'h106;
   localparam logic [8:0] OFS_APP = 9'h143;
   localparam logic [8:0] OFS_MASK = 9'h144;
   localparam logic [8:0] OFS_PULL = 9'h145;
   localparam logic [7:0] RST_LINK = 8'h80;
   localparam logic [7:0] RST_APP = 8'h10;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_PULL = 8'h00;
   // host_link_setup fields
   localparam int B_LINK_TWO_WIRE = 7;
   localparam int B_CONT_HS = 6;
   localparam int B_FAST_PLUS = 5;
   localparam int B_LINK_SUPPLY = 4;
   // app_setup_first fields
   localparam int B_STUCK_TO = 4;
   localparam int B_IN_SUPPLY = 3;
   localparam int B_IRQ_OD = 1;
   localparam int B_IRQ_HIGH = 0;
   // rail_event_masking fields
   localparam int B_IO_LOCK_DIS = 7;
   localparam int B_PG_HOLD_B = 6;
   localparam int B_PG_HOLD_A = 5;
   localparam int B_OC_B_HI = 4;
   localparam int B_OC_B_LO = 3;
   localparam int B_OC_A_HI = 2;
   localparam int B_OC_A_LO = 1;
   localparam int B_RELOAD = 0;
   // pin_pull_setup fields
   localparam int B_PULL4 = 4;
   localparam int B_PULL3 = 3;
   localparam int B_PULL2 = 2;
   localparam int B_PULL1 = 1;
   // Overcurrent blanking codes
   localparam logic [1:0] OC_NEVER = 2'h0;
   localparam logic [1:0] OC_SHORT = 2'h1;
   localparam logic [1:0] OC_MID = 2'h2;
   localparam logic [1:0] OC_LONG = 2'h3;
   // Timing, least times rounded up to whole cycles
   localparam int CLK_PERIOD_NS = 4;
   localparam int STUCK_CLOCK_MS = 35;
   localparam int STUCK_CLOCK_CYCLES =
      (STUCK_CLOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_SHORT_US = 2;
   localparam int BLANK_MID_US = 10;
   localparam int BLANK_LONG_US = 50;
   localparam int BLANK_SHORT_CYCLES = (BLANK_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_MID_CYCLES = (BLANK_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_LONG_CYCLES = (BLANK_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STUCK_CNT_W = 24;
   localparam int BLANK_CNT_W = 14;
endpackage

//--- src/pmuc_stuck_clock.sv
// Two-wire stuck-clock watchdog issuing a one-cycle link logic reset
`timescale 1ns/10ps
`default_nettype none

module pmuc_stuck_clock import pmuc_pkg::*; #(
   parameter int LIMIT_CYCLES = STUCK_CLOCK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstSync_n,
   input wire logic timeoutEnable,
   input wire logic twoWireMode,
   input wire logic clockLow,
   output logic linkResetPulse
);
   typedef struct packed {
      logic [STUCK_CNT_W-1:0] count;
      logic fired;
      logic pulse;
   } pmuc_stuck_state_type;

   pmuc_stuck_state_type state;
   pmuc_stuck_state_type next_state;

   // Fires once per low period; re-arms when the clock goes high, the timeout is disabled or two-wire mode ends
   always_comb begin
      next_state = state;
      next_state.pulse = 1'b0;
      if (!timeoutEnable || !twoWireMode || !clockLow) begin
         next_state.count = '0;
         next_state.fired = 1'b0;
      end else if (!state.fired) begin
         if (state.count == STUCK_CNT_W'(LIMIT_CYCLES)) begin
            next_state.fired = 1'b1;
            next_state.pulse = 1'b1;
         end else begin
            next_state.count = state.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign linkResetPulse = state.pulse;
endmodule

`default_nettype wire

//--- test/pmuc_app_config_regs_tb.sv
// Self-checking bench for the application configuration register group
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin \
   $display("wrong value %s expected %h seen %h", nm, e, g); nMismatch++; end end

module pmuc_app_config_regs_tb;
   import pmuc_pkg::*;
   // Short counts keep the run brief
   localparam int STUCK = 40;
   localparam int TAIL [4] = '{0, 4, 8, 12};
   logic clk_sys, reset_n, regWrite, regRead, regRdValid;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0] regWrData, regRdData, rd;
   logic sclPin, ioPinZeroPin, ioPinZeroIsInput, ioPinTwoIsInput, ioPinTwoIsOpenDrain;
   logic ioPinThreeIsInput, ioPinThreeIsOpenDrain, irqActive, ioRailLow;
   logic railARamp, railBRamp, pgoodRawA, pgoodRawB, ocHitA, ocHitB;
   logic linkFourWire, contHighSpeedEn, fastPlusTimingEn, linkSupplySel, linkLogicReset;
   logic inputPinSupplySel, irqOut, irqOe, ioLockoutCompEn, ioLockoutActive;
   logic pgoodA, pgoodB, ocEventA, ocEventB, otpReloadTrigger;
   logic pin1PullDown, pin2PullDown, pin2PullUp, pin3PullDown, pin3PullUp, pin4PullDown;
   int nMismatch = 0, checksDone = 0, cycles = 0, rstPulses = 0, reloadPulses = 0;

   pmuc_app_config_regs #(.STUCK_CYCLES(STUCK), .BLANK_SHORT(4), .BLANK_MID(8),
      .BLANK_LONG(12)) pmuc_app_config_regs_inst (.clk_sys, .reset_n, .regAddr,
      .regWrite, .regWrData, .regRead, .regRdData, .regRdValid, .sclPin, .ioPinZeroPin,
      .ioPinZeroIsInput, .ioPinTwoIsInput, .ioPinTwoIsOpenDrain, .ioPinThreeIsInput,
      .ioPinThreeIsOpenDrain, .irqActive, .ioRailLow, .railARamp, .railBRamp,
      .pgoodRawA, .pgoodRawB, .ocHitA, .ocHitB, .linkFourWire, .contHighSpeedEn,
      .fastPlusTimingEn, .linkSupplySel, .linkLogicReset, .inputPinSupplySel, .irqOut,
      .irqOe, .ioLockoutCompEn, .ioLockoutActive, .pgoodA, .pgoodB, .ocEventA,
      .ocEventB, .otpReloadTrigger, .pin1PullDown, .pin2PullDown, .pin2PullUp,
      .pin3PullDown, .pin3PullUp, .pin4PullDown);

   pmuc_host_model pmuc_host_model_inst (.clk_sys, .regAddr, .regWrite, .regWrData,
      .regRead, .regRdData, .regRdValid);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Pulse counters and hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (linkLogicReset === 1'b1) rstPulses++;
      if (otpReloadTrigger === 1'b1) reloadPulses++;
      if (cycles == 20000) begin
         nMismatch++;
         endOfTest();
      end
   end

   task automatic endOfTest();
      if (nMismatch == 0 && checksDone > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Ends on an edge; outputs read there still hold the previous cycle's flops
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      pmuc_host_model_inst.writeReg(a, d);
   endtask

   task automatic checkReset();
      logic [7:0] exp [4] = '{RST_LINK, RST_APP, RST_MASK, RST_PULL};
      logic [8:0] ofs [4] = '{OFS_LINK, OFS_APP, OFS_MASK, OFS_PULL};
      for (int i = 0; i < 4; i++) begin
         pmuc_host_model_inst.readReg(ofs[i], rd);
         `CHK("reset value", exp[i], rd)
      end
      pmuc_host_model_inst.readReg(9'h107, rd);
      `CHK("unmapped read", 8'h00, rd)
      `CHK("irq idle", 2'b11, {irqOut, irqOe})
   endtask

   task automatic checkLink();
      @(posedge clk_sys);
      ioPinThreeIsInput <= 1'b1;
      wr(OFS_PULL, 8'h1e);
      wr(OFS_LINK, 8'h60);
      settle(3);
      `CHK("four-wire", 3'b100, {linkFourWire, pin3PullDown, pin4PullDown})
      `CHK("speed on", 2'b11, {contHighSpeedEn, fastPlusTimingEn})
      `CHK("link supply", 1'b0, linkSupplySel)
      wr(OFS_LINK, 8'h90);
      settle(3);
      `CHK("two-wire", 3'b011, {linkFourWire, pin3PullDown, pin4PullDown})
      `CHK("speed off", 2'b00, {contHighSpeedEn, fastPlusTimingEn})
      `CHK("link supply", 1'b1, linkSupplySel)
   endtask

   // All drive and polarity codes, pending and idle
   task automatic checkIrq();
      logic [1:0] exp;
      for (int c = 0; c < 8; c++) begin
         wr(OFS_APP, {6'h06, c[1:0]});
         @(posedge clk_sys);
         irqActive <= c[2];
         settle(3);
         exp = c[1] ? {1'b0, c[2] ^ c[0]} : {~(c[2] ^ c[0]), 1'b1};
         `CHK("irq pin", exp, {irqOut, irqOe})
      end
      `CHK("input supply", 1'b1, inputPinSupplySel)
      irqActive <= 1'b0;
      wr(OFS_APP, 8'h10);
   endtask

   task automatic checkRail();
      @(posedge clk_sys);
      ioRailLow <= 1'b1;
      pgoodRawA <= 1'b1;
      pgoodRawB <= 1'b1;
      settle(3);
      `CHK("lockout on", 2'b11, {ioLockoutCompEn, ioLockoutActive})
      wr(OFS_MASK, 8'he0);
      @(posedge clk_sys);
      railARamp <= 1'b1;
      railBRamp <= 1'b1;
      settle(3);
      `CHK("lockout off", 2'b00, {ioLockoutCompEn, ioLockoutActive})
      pgoodRawA <= 1'b0;
      pgoodRawB <= 1'b0;
      settle(3);
      `CHK("pgood held", 2'b11, {pgoodA, pgoodB})
      wr(OFS_MASK, 8'h80);
      settle(3);
      `CHK("pgood follows", 2'b00, {pgoodA, pgoodB})
      railARamp <= 1'b0;
      railBRamp <= 1'b0;
   endtask

   // Hit held through ramp and tail on both rails
   task automatic checkBlank(input int code);
      wr(OFS_MASK, {3'h0, code[1:0], code[1:0], 1'b0});
      @(posedge clk_sys);
      railARamp <= 1'b1;
      railBRamp <= 1'b1;
      ocHitA <= 1'b1;
      ocHitB <= 1'b1;
      settle(4);
      `CHK("event in ramp", {2{code == 0}}, {ocEventA, ocEventB})
      railARamp <= 1'b0;
      railBRamp <= 1'b0;
      if (code != 0) begin
         settle(TAIL[code] + 1); // Last blanked cycle of the tail
         `CHK("event in tail", 2'b00, {ocEventA, ocEventB})
      end
      settle(1);
      `CHK("event after", 2'b11, {ocEventA, ocEventB})
      ocHitA <= 1'b0;
      ocHitB <= 1'b0;
   endtask

   task automatic checkStuck(input logic [7:0] app, input int expPulses);
      wr(OFS_APP, app);
      settle(2);
      rstPulses = 0;
      sclPin <= 1'b0;
      settle(STUCK + 3); // Last edge before the pulse may show
      `CHK("early reset", 0, rstPulses)
      settle(25);
      `CHK("link resets", expPulses, rstPulses)
      `CHK("link reset idle", 1'b0, linkLogicReset)
      sclPin <= 1'b1;
      settle(3);
   endtask

   task automatic checkReload(input logic isIn, input int expPulses);
      @(posedge clk_sys);
      ioPinZeroIsInput <= isIn;
      ioPinZeroPin <= 1'b0;
      settle(5);
      reloadPulses = 0;
      ioPinZeroPin <= 1'b1;
      settle(8);
      `CHK("reload", expPulses, reloadPulses)
      `CHK("reload idle", 1'b0, otpReloadTrigger)
   endtask

   // Reserved bits set alongside, they must change nothing
   task automatic checkPull(input logic [7:0] d, input logic twoIn, input logic [5:0] exp);
      logic [5:0] got;
      wr(OFS_PULL, d);
      @(posedge clk_sys);
      ioPinTwoIsInput <= twoIn;
      ioPinTwoIsOpenDrain <= ~twoIn;
      ioPinThreeIsInput <= ~twoIn;
      ioPinThreeIsOpenDrain <= twoIn;
      settle(3);
      got = {pin1PullDown, pin2PullDown, pin2PullUp, pin3PullDown,
         pin3PullUp, pin4PullDown};
      `CHK("pulls", exp, got)
   endtask

   initial begin
      {sclPin, ioPinZeroIsInput, ioPinTwoIsOpenDrain, ioPinThreeIsOpenDrain} = 4'hf;
      {ioPinZeroPin, ioPinTwoIsInput, ioPinThreeIsInput, irqActive, ioRailLow} = 5'h00;
      {railARamp, railBRamp, pgoodRawA, pgoodRawB, ocHitA, ocHitB} = 6'h00;
      reset_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle(4);
      checkReset();
      checkLink();
      checkIrq();
      checkRail();
      for (int c = 0; c < 4; c++) checkBlank(c);
      checkStuck(8'h10, 1);
      checkStuck(8'h00, 0);
      wr(OFS_MASK, 8'h01);
      checkReload(1'b1, 1);
      checkReload(1'b0, 0);
      wr(OFS_MASK, 8'h00);
      checkReload(1'b1, 0);
      checkPull(8'hfe, 1'b1, 6'b110011);
      checkPull(8'he6, 1'b0, 6'b101000);
      checkPull(8'he0, 1'b1, 6'b000000);
      endOfTest();
   end
endmodule
`default_nettype wire

//--- test/pmuc_host_model.sv
// Host side model issuing register writes and reads on the strobe port
`timescale 1ns/10ps
`default_nettype none

module pmuc_host_model import pmuc_pkg::*; (
   input wire logic clk_sys,
   output logic [ADDR_W-1:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWrData,
   output logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   // Idle bus at time zero
   initial begin
      regAddr = '0;
      regWrite = 1'b0;
      regWrData = 8'h00;
      regRead = 1'b0;
   end

   // Page holding these registers taken as already selected
   task automatic writeReg(input logic [8:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      regAddr <= addr;
      regWrData <= data;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regAddr <= ~addr; // No stale address once released
      regWrData <= ~data;
   endtask

   // Read waits for the valid pulse under a bound
   task automatic readReg(input logic [8:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      regAddr <= addr;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      regAddr <= ~addr;
      data = 8'hxx;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_sys);
         if (regRdValid === 1'b1) begin
            data = regRdData;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire
